// File: ccaa_capture_compare.sv
// two capture/compare arrays with four reloadable timers, wishbone registers and one interrupt
// assumes pins and external count inputs are asynchronous; gpt overflow pulse is on clk_sys
//
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ccaa_map.svh"
// Function
// - 32 channels, 1 or 8 cycle resolution
// - four 16-bit timers with reload registers
// - timer clock from prescaler or gpt overflow
// - first timer per array counts external input
// - 16 registers per array, allocatable, capture/compare
// - each register owns one port pin
// - capture copies allocated timer into register
// - every capture raises its own request
// - capture edge rising, falling or both
// - compare continuously, act on equality
// - mode 0 interrupt only, repeatable
// - mode 1 toggles pin, repeatable
// - mode 2 interrupt once per period
// - mode 3 set on match, clear on overflow
// - double register pair toggles one pin
// - single event option stops a compare channel after one event; capture ignores it
module ccaa_capture_compare #(
  parameter int NCH = 32,
  parameter int TW  = 16
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire logic [`CCAA_ADR_W-1:0] wb_adr_i,
  input  wire logic [31:0]           wb_dat_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic                  wb_we_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire ccaa_pkg::ccaa_pins_t  pinsIn,
  input  wire logic                  gptOverflowIn,
  output logic      [NCH-1:0]        ccPinOut,
  output logic      [NCH-1:0]        ccPinOe,
  output logic                       irq
);
  import ccaa_pkg::*;

  function automatic logic [31:0] mergeWord(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [1:0] timerOf(input int ch, input logic tsel);
    return {1'(ch / 16), tsel};
  endfunction

  ccaa_pins_t           s1_q, s2_q, s3_q;
  logic [TW-1:0]        val_q [NCH], val_d [NCH];
  ccaa_cfg_t            cfg_q [NCH], cfg_d [NCH];
  logic [NCH-1:0]       pin_q, pin_d, done_q, done_d, armed_q, armed_d, mprev_q, mprev_d;
  logic [NCH-1:0]       stat_q, stat_d, mask_q, mask_d;
  logic [NCH-1:0]       hitEv, capEv, chOvf, setEv;
  logic [TW-1:0]        tmr_q [4], tmr_d [4], rld_q [4], rld_d [4];
  ccaa_tctl_t           tctl_q [4], tctl_d [4];
  logic [3:0]           tovf;
  logic [7:0]           pre_q, pre_d;
  logic [2:0]           slot_q, slot_d;
  logic                 stag_q, stag_d, ack_q, ack_d;
  logic [31:0]          dat_q, dat_d, rdData;
  logic                 busReq, busWr;
  logic [`CCAA_IDX_W-1:0] idx;

  assign busReq = wb_cyc_i & wb_stb_i & ~ack_q;
  assign busWr  = busReq & wb_we_i;
  assign idx    = wb_adr_i[`CCAA_IDX_LSB +: `CCAA_IDX_W];

  // pin synchronisers: only s2 and s3 feed logic
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pinsIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // timers and prescaler
  always_comb begin
    logic       tick;
    logic [7:0] pm;
    tick = 1'b0;
    pm = '0;
    pre_d = pre_q + 8'h01;
    tovf = '0;
    for (int t = 0; t < 4; t++) begin
      tmr_d[t] = tmr_q[t];
      rld_d[t] = rld_q[t];
      tctl_d[t] = tctl_q[t];
      // staggered prescaler ticks only on slot wrap, so every channel sees each count
      // limitation: gpt and external sources are not slowed, staggered channels may miss them
      pm = ((`CCAA_PRE_MASK1 << tctl_q[t].pre) - `CCAA_PRE_MASK1) | ({8{stag_q}} & 8'(`CCAA_STAG_LAST));
      case (tctl_q[t].src)
        `CCAA_SRC_PRE: tick = (pre_q & pm) == pm;
        `CCAA_SRC_GPT: tick = gptOverflowIn;
        // external count on timer a only
        `CCAA_SRC_EXT: tick = (t % 2 == 0) && s2_q.ext[t/2] && !s3_q.ext[t/2];
        default:       tick = 1'b0;
      endcase
      if (tctl_q[t].run && tick) begin
        if (tmr_q[t] == `CCAA_TMR_MAX) begin
          tmr_d[t] = rld_q[t];
          tovf[t] = 1'b1;
        end else begin
          tmr_d[t] = tmr_q[t] + 16'h0001;
        end
      end
      if (busWr && idx[`CCAA_IDX_W-1:2] == 6'(t + (`CCAA_IDX_TMR >> 2))) begin
        case (idx[1:0])
          `CCAA_TREG_CNT: tmr_d[t] = TW'(mergeWord(32'(tmr_q[t]), wb_dat_i, wb_sel_i));
          `CCAA_TREG_RLD: rld_d[t] = TW'(mergeWord(32'(rld_q[t]), wb_dat_i, wb_sel_i));
          `CCAA_TREG_CTL: tctl_d[t] = ccaa_tctl_t'(wb_dat_i[$bits(ccaa_tctl_t)-1:0]);
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pre_q <= '0;
      for (int t = 0; t < 4; t++) begin
        tmr_q[t] <= `CCAA_VAL_RST;
        rld_q[t] <= `CCAA_VAL_RST;
        tctl_q[t] <= ccaa_tctl_t'(`CCAA_TCTL_RST);
      end
    end else begin
      pre_q <= pre_d;
      tmr_q <= tmr_d;
      rld_q <= rld_d;
      tctl_q <= tctl_d;
    end
  end

  // channels
  always_comb begin
    logic [TW-1:0] tv;
    logic          hit, ev, rise, fall;
    logic [1:0]    ti;
    tv = '0;
    hit = 1'b0;
    ev = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    ti = '0;
    val_d = val_q;
    cfg_d = cfg_q;
    pin_d = pin_q;
    done_d = done_q;
    armed_d = armed_q;
    mprev_d = mprev_q;
    mask_d = mask_q;
    hitEv = '0;
    capEv = '0;
    chOvf = '0;
    // staggered evaluation stretches resolution to eight cycles
    slot_d = slot_q + 3'h1;
    stag_d = stag_q;
    for (int i = 0; i < NCH; i++) begin
      ti = timerOf(i, cfg_q[i].tsel);
      tv = tmr_q[ti];
      chOvf[i] = tovf[ti];
      rise = s2_q.ccIn[i] & ~s3_q.ccIn[i];
      fall = ~s2_q.ccIn[i] & s3_q.ccIn[i];
      capEv[i] = cfg_q[i].mode == CCAA_CAP &&
                 ((cfg_q[i].edgeSel[`CCAA_EDGE_RISE] && rise) || (cfg_q[i].edgeSel[`CCAA_EDGE_FALL] && fall));
      if (capEv[i]) begin
        val_d[i] = tv;
      end
      ev = !stag_q || slot_q == 3'(i);
      hit = tmr_q[ti] == val_q[i];
      if (ev) begin
        mprev_d[i] = hit;
      end
      hitEv[i] = cfg_q[i].mode inside {CCAA_CMP0, CCAA_CMP1, CCAA_CMP2, CCAA_CMP3} && ev && hit &&
                 !mprev_q[i] && !done_q[i] && (armed_q[i] || cfg_q[i].mode inside {CCAA_CMP0, CCAA_CMP1});
      if (chOvf[i]) begin
        armed_d[i] = 1'b1;
        if (cfg_q[i].mode == CCAA_CMP3) begin
          pin_d[i] = 1'b0;
        end
      end
      if (hitEv[i]) begin
        case (cfg_q[i].mode)
          CCAA_CMP1: pin_d[i] = ~pin_q[i];
          CCAA_CMP3: begin
            pin_d[i] = 1'b1;
            armed_d[i] = 1'b0;
          end
          CCAA_CMP2: armed_d[i] = 1'b0;
          default: ;
        endcase
        if (cfg_q[i].single) begin
          done_d[i] = 1'b1;
        end
      end
    end
    // upper partner toggles the shared pin
    for (int i = 0; i < NCH - `CCAA_DBL_SPAN; i++) begin
      if (i % 16 < `CCAA_DBL_SPAN && cfg_q[i].dbl && hitEv[i + `CCAA_DBL_SPAN]) begin
        pin_d[i] = ~pin_d[i];
      end
    end
    // capture and compare raise the channel request
    setEv = capEv | hitEv;
    stat_d = stat_q | setEv;
    if (busWr) begin
      if ((idx & `CCAA_IDX_CH_M) == `CCAA_IDX_VAL) begin
        val_d[idx[4:0]] = TW'(mergeWord(32'(val_q[idx[4:0]]), wb_dat_i, wb_sel_i));
      end
      if ((idx & `CCAA_IDX_CH_M) == `CCAA_IDX_CFG && wb_sel_i[0]) begin
        cfg_d[idx[4:0]] = ccaa_cfg_t'(wb_dat_i[$bits(ccaa_cfg_t)-1:0]);
        done_d[idx[4:0]] = 1'b0;
        armed_d[idx[4:0]] = 1'b1;
      end
      // set wins over a write-one clear in the same cycle
      if (idx == `CCAA_IDX_STAT) begin
        stat_d = (stat_q & ~mergeWord(32'h0, wb_dat_i, wb_sel_i)) | setEv;
      end
      if (idx == `CCAA_IDX_MASK) begin
        mask_d = mergeWord(mask_q, wb_dat_i, wb_sel_i);
      end
      if (idx == `CCAA_IDX_GCTL && wb_sel_i[0]) begin
        stag_d = wb_dat_i[0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int i = 0; i < NCH; i++) begin
        val_q[i] <= `CCAA_VAL_RST;
        cfg_q[i] <= ccaa_cfg_t'(`CCAA_CFG_RST);
      end
      pin_q <= '0;
      done_q <= '0;
      armed_q <= '1;
      mprev_q <= '0;
      stat_q <= '0;
      mask_q <= '0;
      slot_q <= '0;
      stag_q <= 1'b0;
    end else begin
      val_q <= val_d;
      cfg_q <= cfg_d;
      pin_q <= pin_d;
      done_q <= done_d;
      armed_q <= armed_d;
      mprev_q <= mprev_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      slot_q <= slot_d;
      stag_q <= stag_d;
    end
  end

  // bus read mux; unmapped words read zero
  always_comb begin
    logic [1:0] t;
    t = idx[3:2];
    rdData = '0;
    if ((idx & `CCAA_IDX_CH_M) == `CCAA_IDX_VAL) begin
      rdData = 32'(val_q[idx[4:0]]);
    end else if ((idx & `CCAA_IDX_CH_M) == `CCAA_IDX_CFG) begin
      rdData = 32'(cfg_q[idx[4:0]]);
    end else if ((idx & `CCAA_IDX_TM_M) == `CCAA_IDX_TMR) begin
      case (idx[1:0])
        `CCAA_TREG_CNT: rdData = 32'(tmr_q[t]);
        `CCAA_TREG_RLD: rdData = 32'(rld_q[t]);
        `CCAA_TREG_CTL: rdData = 32'(tctl_q[t]);
        default:        rdData = '0;
      endcase
    end else if (idx == `CCAA_IDX_STAT) begin
      rdData = stat_q;
    end else if (idx == `CCAA_IDX_MASK) begin
      rdData = mask_q;
    end else if (idx == `CCAA_IDX_GCTL) begin
      rdData = 32'(stag_q);
    end
    ack_d = busReq;
    dat_d = busReq ? rdData : '0;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign irq      = |(stat_q & mask_q);
  assign ccPinOut = pin_q;
  // pin driven only in compare function
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      // a double partner alone never enables the pin; the lower channel must be in mode 1 or 3
      ccPinOe[i] = cfg_q[i].mode inside {CCAA_CMP1, CCAA_CMP3};
    end
  end

  a_reload_after_ovf: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tovf[1] && !busWr |=> tmr_q[1] == $past(rld_q[1]))
    else $error("timer did not reload on overflow");
  a_capture_value: assert property (@(posedge clk_sys) disable iff (!rst_n)
    capEv[0] && !busWr |=> val_q[0] == $past(cfg_q[0].tsel ? tmr_q[1] : tmr_q[0]))
    else $error("capture did not latch timer");
  a_capture_request: assert property (@(posedge clk_sys) disable iff (!rst_n)
    capEv[0] |=> stat_q[0])
    else $error("capture raised no request");
  a_ext_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tctl_q[0].run && tctl_q[0].src == `CCAA_SRC_EXT && !(s2_q.ext[0] && !s3_q.ext[0]) && !busWr
    |=> tmr_q[0] == $past(tmr_q[0]))
    else $error("external timer moved without an input edge");
  a_mode1_toggle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    hitEv[1] && cfg_q[1].mode == CCAA_CMP1 && !hitEv[9] |=> pin_q[1] != $past(pin_q[1]))
    else $error("mode 1 pin did not toggle");
  a_mode3_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    hitEv[2] && cfg_q[2].mode == CCAA_CMP3 && !cfg_q[2].dbl && !busWr |=> pin_q[2] && !armed_q[2])
    else $error("mode 3 pin not set on match");
  a_mode3_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    chOvf[2] && !hitEv[2] && cfg_q[2].mode == CCAA_CMP3 && !hitEv[10] |=> !pin_q[2])
    else $error("mode 3 pin not cleared on overflow");
  a_mode2_once: assert property (@(posedge clk_sys) disable iff (!rst_n)
    hitEv[4] && cfg_q[4].mode == CCAA_CMP2 && !chOvf[4] && !busWr |=> !armed_q[4] ##1 !hitEv[4])
    else $error("mode 2 fired twice in a period");
  a_mode0_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
    hitEv[3] && cfg_q[3].mode == CCAA_CMP0 && !hitEv[11] |=> pin_q[3] == $past(pin_q[3]) && stat_q[3])
    else $error("mode 0 touched the pin");
  a_double_toggle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    hitEv[14] && cfg_q[6].dbl && !hitEv[6] && !chOvf[6] |=> pin_q[6] != $past(pin_q[6]))
    else $error("double partner did not toggle the shared pin");
  a_single_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
    hitEv[5] && cfg_q[5].single && !busWr |=> done_q[5])
    else $error("single event did not stop channel");
  a_stagger_slot: assert property (@(posedge clk_sys) disable iff (!rst_n)
    stag_q && hitEv[2] |-> slot_q == 3'h2)
    else $error("staggered channel fired outside its slot");
endmodule
`default_nettype wire

// File: ccaa_capture_compare_bench.sv
// self-checking bench for the capture/compare arrays
// assumes the single-cycle wishbone answer and 2-flop pin sync of the design
`timescale 1ns/100ps
`default_nettype none
module ccaa_capture_compare_bench;
  import ccaa_pkg::*;
  logic        clk_sys, rst_n, wbWe, wbCyc, wbStb, gptOv, wbAck, irq;
  logic [9:0]  wbAdr;
  logic [31:0] wbDat, wbDatO, pinDrive, ccPinOut, ccPinOe, rnd, exq[$];
  logic [3:0]  wbSel;
  logic [1:0]  extDrive;
  ccaa_pins_t  pins;
  int          n_mismatch, tests_run, tog, hi;
  ccaa_capture_compare u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_adr_i(wbAdr), .wb_dat_i(wbDat),
    .wb_sel_i(wbSel), .wb_we_i(wbWe), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .pinsIn(pins), .gptOverflowIn(gptOv), .ccPinOut(ccPinOut), .ccPinOe(ccPinOe),
    .irq(irq));
  ccaa_pin_model u_pins (.pinDrive(pinDrive), .extDrive(extDrive), .ccPinOut(ccPinOut),
    .ccPinOe(ccPinOe), .pinsOut(pins));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("mismatches=%0d comparisons=%0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // one classic cycle; a read leaves its expected word for the monitor
  task automatic bus(input logic [9:0] a, input logic we, input logic [31:0] d);
    int n;
    n = 0;
    wbAdr <= a;
    wbWe  <= we;
    wbDat <= d;
    wbSel <= 4'hF;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    if (!we) exq.push_back(d);
    // ack is sampled at the rising edge; only then is the request released
    do begin
      @(posedge clk_sys);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    if (wbAck !== 1'b1) chk(32'h0, 32'h1);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    bus(a, 1'b0, e);
  endtask
  // read data is compared against the oldest note when the answer shows
  always @(posedge clk_sys) begin
    if (wbAck === 1'b1 && wbWe === 1'b0) begin
      if (exq.size() == 0) chk(wbDatO, 32'hDEAD_BEEF);
      else chk(wbDatO, exq.pop_front());
    end
  end
  // pins 1, 2 and 6 over n cycles, ten periods of a 16-count timer; mode 3 is high about 7 of 16 counts
  task automatic measure(input int n);
    logic last, last6;
    int   tog6;
    tog = 0;
    hi = 0;
    tog6 = 0;
    last = ccPinOut[1];
    last6 = ccPinOut[6];
    repeat (n) begin
      @(negedge clk_sys);
      if (ccPinOut[1] !== last) tog++;
      if (ccPinOut[6] !== last6) tog6++;
      last = ccPinOut[1];
      last6 = ccPinOut[6];
      if (ccPinOut[2] === 1'b1) hi++;
    end
    @(posedge clk_sys);
    chk(32'(tog >= 9 && tog <= 11), 32'h1);
    chk(32'(tog6 >= 19 && tog6 <= 21), 32'h1);
    chk(32'(hi * 16 >= n * 6 && hi * 16 <= n * 8), 32'h1);
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    rst_n = 1'b0; wbAdr = '0; wbDat = '0; wbSel = '0; wbWe = 1'b0; wbCyc = 1'b0; wbStb = 1'b0;
    gptOv = 1'b0; pinDrive = '0; extDrive = '0; n_mismatch = 0; tests_run = 0; rnd = 32'h2;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    rd(10'h140, 32'h0);
    rd(10'h080, 32'h0);
    wr(10'h380, 32'hFFFF_FFFF);
    rd(10'h380, 32'h0);
    rnd = xorshift(rnd);
    wr(10'h100, {16'h0, rnd[15:0]});
    wr(10'h080, 32'h09);
    wr(10'h144, 32'h1);
    pinDrive[0] <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rd(10'h000, {16'h0, rnd[15:0]});
    chk({31'h0, irq}, 32'h1);
    wr(10'h140, 32'h1);
    chk({31'h0, irq}, 32'h0);
    for (int i = 1; i < 4; i++) begin
      wr(10'h080, {24'h0, 3'h0, 2'(i), 3'h1});
      wr(10'h140, 32'h1);
      pinDrive[0] <= 1'b0;
      repeat (8) @(posedge clk_sys);
      rd(10'h140, {31'h0, 1'(i >> 1)});
      wr(10'h140, 32'h1);
      pinDrive[0] <= 1'b1;
      repeat (8) @(posedge clk_sys);
      rd(10'h140, {31'h0, 1'(i)});
    end
    chk({31'h0, irq}, 32'h1);
    wr(10'h144, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(10'h100, 32'h0);
    wr(10'h108, 32'h30);
    repeat (3) begin
      extDrive[0] <= 1'b1;
      repeat (4) @(posedge clk_sys);
      extDrive[0] <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
    wr(10'h108, 32'h0);
    rd(10'h100, 32'h3);
    wr(10'h110, 32'h0);
    wr(10'h118, 32'h28);
    rnd = xorshift(rnd);
    for (int k = 0; k <= int'(rnd[3:0]); k++) begin
      gptOv <= 1'b1;
      @(posedge clk_sys);
      gptOv <= 1'b0;
      repeat (1 + k % 3) @(posedge clk_sys);
    end
    wr(10'h118, 32'h0);
    rd(10'h110, {28'h0, rnd[3:0]} + 32'h1);
    wr(10'h114, 32'hFFF0);
    wr(10'h110, 32'hFFF0);
    wr(10'h004, 32'hFFF8);
    wr(10'h084, 32'h23);
    wr(10'h008, 32'hFFF8);
    wr(10'h088, 32'h25);
    wr(10'h00C, 32'hFFF8);
    wr(10'h08C, 32'h22);
    wr(10'h010, 32'hFFF8);
    wr(10'h090, 32'h24);
    wr(10'h014, 32'hFFF8);
    wr(10'h094, 32'h62);
    wr(10'h018, 32'hFFF2);
    wr(10'h098, 32'hA3);
    wr(10'h038, 32'hFFFA);
    wr(10'h0B8, 32'h22);
    wr(10'h118, 32'h20);
    repeat (20) @(posedge clk_sys);
    chk({29'h0, ccPinOe[2:0]}, 32'h6);
    measure(160);
    wr(10'h140, 32'hFFFF_FFFF);
    repeat (40) @(posedge clk_sys);
    rd(10'h140, 32'h405E);
    wr(10'h148, 32'h1);
    repeat (140) @(posedge clk_sys);
    measure(1280);
    report_and_stop();
  end
endmodule
`default_nettype wire

// File: ccaa_map.svh
// register map, field codes and reset values of the dual capture/compare arrays
// assumes a 32-bit classic wishbone slave with word-aligned byte addresses
`ifndef CCAA_MAP_SVH
`define CCAA_MAP_SVH
`define CCAA_ADR_W      10
`define CCAA_IDX_W      8
`define CCAA_IDX_LSB    2
`define CCAA_IDX_VAL    8'h00
`define CCAA_IDX_CFG    8'h20
`define CCAA_IDX_TMR    8'h40
`define CCAA_IDX_STAT   8'h50
`define CCAA_IDX_MASK   8'h51
`define CCAA_IDX_GCTL   8'h52
`define CCAA_IDX_CH_M   8'hE0
`define CCAA_IDX_TM_M   8'hF0
`define CCAA_TREG_CNT   2'h0
`define CCAA_TREG_RLD   2'h1
`define CCAA_TREG_CTL   2'h2
`define CCAA_TMR_MAX    16'hFFFF
`define CCAA_VAL_RST    16'h0000
`define CCAA_CFG_RST    8'h00
`define CCAA_TCTL_RST   6'h00
`define CCAA_EDGE_RISE  0
`define CCAA_EDGE_FALL  1
`define CCAA_SRC_PRE    2'h0
`define CCAA_SRC_GPT    2'h1
`define CCAA_SRC_EXT    2'h2
`define CCAA_STAG_LAST  3'h7
`define CCAA_PRE_MASK1  8'h01
`define CCAA_DBL_SPAN   8
`endif

// File: ccaa_pin_model.sv
// far-side pin model: external drivers on the channel pins and count inputs
// assumes the bench sets pinDrive/extDrive; channel pins are resolved per output enable
`timescale 1ns/100ps
`default_nettype none
module ccaa_pin_model (
  input  wire logic [31:0]          pinDrive,
  input  wire logic [1:0]           extDrive,
  input  wire logic [31:0]          ccPinOut,
  input  wire logic [31:0]          ccPinOe,
  output var  ccaa_pkg::ccaa_pins_t pinsOut
);
  import ccaa_pkg::*;
  // one pin per register
  // a pin driven by the block wins, so an output channel sees its own level
  assign pinsOut.ccIn = (ccPinOe & ccPinOut) | (~ccPinOe & pinDrive);
  assign pinsOut.ext  = extDrive;
endmodule
`default_nettype wire

// File: ccaa_pkg.sv
// types shared by the capture/compare arrays
// assumes ccaa_map.svh holds the numeric layout
package ccaa_pkg;
  typedef enum logic [2:0] {
    CCAA_OFF  = 3'h0,
    CCAA_CAP  = 3'h1,
    CCAA_CMP0 = 3'h2,
    CCAA_CMP1 = 3'h3,
    CCAA_CMP2 = 3'h4,
    CCAA_CMP3 = 3'h5
  } ccaa_mode_t;
  typedef struct packed {
    logic       dbl;
    logic       single;
    logic       tsel;
    logic [1:0] edgeSel;
    ccaa_mode_t mode;
  } ccaa_cfg_t;
  typedef struct packed {
    logic       run;
    logic [1:0] src;
    logic [2:0] pre;
  } ccaa_tctl_t;
  typedef struct packed {
    logic [31:0] ccIn;
    logic [1:0]  ext;
  } ccaa_pins_t;
endpackage
